/* logic/ncs_pkg.sv */
// constants and types shared by the stored map command sequencer
package ncs_pkg;
    // management addresses
    localparam logic [15:0] NCS_CSR_ADDR = 16'h8000;
    localparam logic [15:0] NCS_MAP_FIRST = 16'h8007;
    localparam logic [15:0] NCS_MAP_LAST = 16'h80f1;
    localparam logic [15:0] NCS_MON_CAP_ADDR = 16'h807a;
    localparam logic [15:0] NCS_RSVD_ADDR = 16'h807c;
    localparam logic [15:0] NCS_CHECKSUM_ADDR = 16'h807d;
    localparam int NCS_MAP_DEPTH = 235;
    localparam int NCS_IDX_W = 8;
    // customer writeable region, as map indices
    localparam logic [7:0] NCS_CUST_FIRST = 8'h77;
    localparam logic [7:0] NCS_CUST_LAST = 8'ha6;
    // control/status field positions
    localparam int NCS_VEND_HI = 15;
    localparam int NCS_VEND_LO = 9;
    localparam int NCS_DIR_BIT = 5;
    localparam int NCS_STAT_HI = 3;
    localparam int NCS_STAT_LO = 2;
    localparam int NCS_EXT_HI = 1;
    localparam int NCS_EXT_LO = 0;
    localparam logic [6:0] NCS_VEND_RESET = 7'h00;
    // command status codes
    localparam logic [1:0] NCS_ST_IDLE = 2'h0;
    localparam logic [1:0] NCS_ST_OK = 2'h1;
    localparam logic [1:0] NCS_ST_BUSY = 2'h2;
    localparam logic [1:0] NCS_ST_FAIL = 2'h3;
    // extended command covering the whole stored map
    localparam logic [1:0] NCS_EXT_ALL = 2'h3;
    // command code is {direction, extended}
    localparam logic [2:0] NCS_CODE_LOAD_ALL = 3'h3;
    localparam logic [2:0] NCS_CODE_COMMIT_ALL = 3'h7;

    typedef enum logic [1:0] {
        NCS_S_IDLE = 2'b00,
        NCS_S_PENDING = 2'b01,
        NCS_S_IN_PROGRESS = 2'b10,
        NCS_S_COMPLETE = 2'b11
    } ncs_state_t;
endpackage : ncs_pkg

/* logic/ncs_arbiter.sv */
// one-at-a-time arbiter for storage shared with the optical monitor
module ncs_arbiter
    import ncs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // requesters, held high while they need the storage
    input wire logic map_req,
    input wire logic mon_req,
    // grants
    output logic map_grant,
    output logic mon_grant
);
    logic map_own_reg;
    logic mon_own_reg;

    // owner keeps the storage until it drops its request
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            map_own_reg <= 1'b0;
            mon_own_reg <= 1'b0;
        end else if (map_own_reg) begin
            map_own_reg <= map_req;
        end else if (mon_own_reg) begin
            mon_own_reg <= mon_req;
        end else if (mon_req) begin
            // a tie goes to the monitor; the map command queues
            mon_own_reg <= 1'b1; // see RQ15
        end else begin
            map_own_reg <= map_req;
        end
    end

    assign map_grant = map_own_reg;
    assign mon_grant = mon_own_reg;
endmodule : ncs_arbiter

/* logic/ncs_storage_engine.sv */
// backing storage and the copy engine between it and the register space
module ncs_storage_engine
    import ncs_pkg::*;
#(
    parameter int DEPTH = NCS_MAP_DEPTH
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // command
    input wire logic start,
    input wire logic [2:0] cmd_code,
    output logic done,
    output logic ok,
    // register space access
    output logic [NCS_IDX_W-1:0] vol_idx,
    output logic vol_we,
    output logic [7:0] vol_wdata,
    input wire logic [7:0] vol_rdata
);
    localparam logic [NCS_IDX_W-1:0] LAST_IDX = NCS_IDX_W'(DEPTH - 1);

    // backing store keeps no reset, like the part it stands for
    logic [7:0] store_mem [DEPTH];
    logic run_reg;
    logic dir_reg;
    logic [NCS_IDX_W-1:0] idx_reg;
    logic done_reg;
    logic ok_reg;
    logic cust;

    assign cust = (idx_reg >= NCS_CUST_FIRST) && (idx_reg <= NCS_CUST_LAST);

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            run_reg <= 1'b0;
            dir_reg <= 1'b0;
            idx_reg <= '0;
            done_reg <= 1'b0;
            ok_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (start && !run_reg) begin
                if (cmd_code[1:0] == NCS_EXT_ALL) begin // see RQ8
                    run_reg <= 1'b1;
                    dir_reg <= cmd_code[2];
                    idx_reg <= '0;
                end else begin
                    // vendor codes are not implemented: report failure
                    done_reg <= 1'b1; // see RQ22
                    ok_reg <= 1'b0;
                end
            end else if (run_reg) begin
                if (idx_reg == LAST_IDX) begin
                    run_reg <= 1'b0;
                    done_reg <= 1'b1; // see RQ22
                    ok_reg <= 1'b1;
                end else begin
                    idx_reg <= idx_reg + 1'b1;
                end
            end
        end
    end

    // commit only touches the customer region
    always_ff @(posedge core_clk) begin
        if (run_reg && dir_reg && cust) begin
            store_mem[idx_reg] <= vol_rdata; // see RQ13, RQ20, RQ21
        end
    end

    assign vol_idx = idx_reg;
    assign vol_we = run_reg && !dir_reg; // see RQ13
    assign vol_wdata = store_mem[idx_reg];
    assign done = done_reg;
    assign ok = ok_reg;
endmodule : ncs_storage_engine

/* logic/ncs_sequencer.sv */
// stored map command sequencer: control/status register and map space
// Summary of operation
// RQ1: every map location reads directly at its address, no command needed.
// RQ2: management writes to the map stay volatile until a commit command.
// RQ3: reset reloads the whole stored map into the register space.
// RQ4: read command with extended 11 reloads everything, dropping changes.
// RQ5: register at 0x8000; 15:9 vendor rw, 8:6 and 4 read zero.
// RQ6: bit 5 zero loads from storage, one commits to storage.
// RQ7: status 3:2 is 00 idle, 10 busy, 01 ok, 11 failed.
// RQ8: extended 11 covers all contents; other codes are vendor defined.
// RQ9: direction and extended bits hold from start until idle again.
// RQ10: host writes the register only after it has read idle.
// RQ11: reading the register after completion returns outcome, goes idle.
// RQ12: a write while idle starts a command and enters pending.
// RQ13: load copies storage to registers; commit copies back where writeable.
// RQ14: writes to the register are ignored from start until idle.
// RQ15: one command at a time with the monitor; second one queues.
// RQ16: pending moves to in progress only once storage is free.
// RQ17: engine completion enters complete with status 01 or 11.
// RQ18: reset either idles or uploads and ends complete with outcome.
// RQ19: command code is direction bit joined with the extended field.
// RQ20: customer portion can be committed through a write command.
// RQ21: basic and vendor storage regions are never altered.
// RQ22: engine finishes with a one-cycle done pulse and success flag.
module ncs_sequencer
    import ncs_pkg::*;
#(
    parameter bit RESET_UPLOAD = 1'b1,
    parameter logic [7:0] MON_CAP_VALUE = 8'h00
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // management register port
    input wire logic [15:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] mgmt_rdata,
    // shared storage with the optical monitor subsystem
    input wire logic mon_req,
    output logic mon_grant,
    // status seen by the rest of the module
    output logic [1:0] cmd_status,
    output logic [2:0] cmd_code
);
    ncs_state_t state_reg;
    ncs_state_t state_next;
    logic [6:0] vend_reg;
    logic dir_reg;
    logic [1:0] ext_reg;
    logic [1:0] outcome_reg;
    logic [15:0] rdata_reg;
    logic [7:0] vol_mem [NCS_MAP_DEPTH];
    logic csr_wr;
    logic csr_rd;
    logic map_hit;
    logic map_wr_ok;
    logic [NCS_IDX_W-1:0] mgmt_idx;
    logic [15:0] csr_value;
    logic map_grant;
    logic eng_start;
    logic eng_done;
    logic eng_ok;
    logic [NCS_IDX_W-1:0] eng_idx;
    logic eng_we;
    logic [7:0] eng_wdata;
    logic [7:0] eng_rdata;

    assign csr_wr = mgmt_wr && (mgmt_addr == NCS_CSR_ADDR);
    assign csr_rd = mgmt_rd && (mgmt_addr == NCS_CSR_ADDR);
    assign map_hit = (mgmt_addr >= NCS_MAP_FIRST) &&
        (mgmt_addr <= NCS_MAP_LAST);
    assign mgmt_idx = NCS_IDX_W'(mgmt_addr - NCS_MAP_FIRST);
    // capability, reserved and checksum bytes are not writeable by the host
    assign map_wr_ok = mgmt_wr && map_hit &&
        (mgmt_addr != NCS_MON_CAP_ADDR) &&
        (mgmt_addr != NCS_RSVD_ADDR) &&
        (mgmt_addr != NCS_CHECKSUM_ADDR);

    // state machine
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            NCS_S_IDLE: begin
                if (csr_wr) begin
                    state_next = NCS_S_PENDING; // see RQ12
                end
            end
            NCS_S_PENDING: begin
                if (map_grant) begin
                    state_next = NCS_S_IN_PROGRESS; // see RQ16
                end
            end
            NCS_S_IN_PROGRESS: begin
                if (eng_done) begin
                    state_next = NCS_S_COMPLETE; // see RQ17
                end
            end
            NCS_S_COMPLETE: begin
                if (csr_rd) begin
                    state_next = NCS_S_IDLE; // see RQ11
                end
            end
            default: begin
                state_next = NCS_S_IDLE;
            end
        endcase
    end

    // reset may go straight into an upload of the stored map
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            if (RESET_UPLOAD) begin
                state_reg <= NCS_S_PENDING; // see RQ3, RQ18
            end else begin
                state_reg <= NCS_S_IDLE; // see RQ18
            end
        end else begin
            state_reg <= state_next;
        end
    end

    // command fields, frozen outside idle
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            vend_reg <= NCS_VEND_RESET;
            dir_reg <= NCS_CODE_LOAD_ALL[2];
            ext_reg <= NCS_CODE_LOAD_ALL[1:0];
        end else if (csr_wr && state_reg == NCS_S_IDLE) begin // see RQ14
            vend_reg <= mgmt_wdata[NCS_VEND_HI:NCS_VEND_LO]; // see RQ5
            dir_reg <= mgmt_wdata[NCS_DIR_BIT]; // see RQ6
            ext_reg <= mgmt_wdata[NCS_EXT_HI:NCS_EXT_LO]; // see RQ9
        end
    end

    // outcome latched from the engine's done pulse
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            outcome_reg <= NCS_ST_IDLE;
        end else if (state_reg == NCS_S_IN_PROGRESS && eng_done) begin
            outcome_reg <= eng_ok ? NCS_ST_OK : NCS_ST_FAIL; // see RQ17
        end
    end

    // status field follows the state
    always_comb begin
        case (state_reg)
            NCS_S_IDLE: cmd_status = NCS_ST_IDLE; // see RQ7
            NCS_S_PENDING: cmd_status = NCS_ST_BUSY; // see RQ15
            NCS_S_IN_PROGRESS: cmd_status = NCS_ST_BUSY;
            NCS_S_COMPLETE: cmd_status = outcome_reg;
            default: cmd_status = NCS_ST_IDLE;
        endcase
    end

    assign cmd_code = {dir_reg, ext_reg}; // see RQ19
    assign csr_value = {vend_reg, 3'h0, dir_reg, 1'b0, cmd_status,
        ext_reg}; // see RQ5

    // volatile register space; engine has priority over host writes
    always_ff @(posedge core_clk) begin
        if (eng_we) begin
            vol_mem[eng_idx] <= eng_wdata; // see RQ4, RQ13
        end else if (map_wr_ok) begin
            vol_mem[mgmt_idx] <= mgmt_wdata[7:0]; // see RQ2
        end
    end
    assign eng_rdata = vol_mem[eng_idx];

    // read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rdata_reg <= 16'h0000;
        end else if (mgmt_rd) begin
            if (mgmt_addr == NCS_CSR_ADDR) begin
                rdata_reg <= csr_value; // see RQ11
            end else if (mgmt_addr == NCS_MON_CAP_ADDR) begin
                rdata_reg <= {8'h00, MON_CAP_VALUE};
            end else if (mgmt_addr == NCS_RSVD_ADDR) begin
                rdata_reg <= 16'h0000;
            end else if (map_hit) begin
                rdata_reg <= {8'h00, vol_mem[mgmt_idx]}; // see RQ1
            end else begin
                rdata_reg <= 16'h0000;
            end
        end
    end
    assign mgmt_rdata = rdata_reg;

    // storage request held from pending until complete
    assign eng_start = (state_reg == NCS_S_PENDING) && map_grant;

    ncs_arbiter u_arbiter (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .map_req((state_reg == NCS_S_PENDING) ||
            (state_reg == NCS_S_IN_PROGRESS)), // see RQ15
        .mon_req(mon_req),
        .map_grant(map_grant),
        .mon_grant(mon_grant)
    );

    ncs_storage_engine #(
        .DEPTH(NCS_MAP_DEPTH)
    ) u_engine (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .start(eng_start),
        .cmd_code(cmd_code),
        .done(eng_done),
        .ok(eng_ok),
        .vol_idx(eng_idx),
        .vol_we(eng_we),
        .vol_wdata(eng_wdata),
        .vol_rdata(eng_rdata)
    );
endmodule : ncs_sequencer

/* bench/ncs_sequencer_properties.sv */
// checker watching the stored map command sequencer ports
module ncs_sequencer_properties
    import ncs_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // management register port
    input wire logic [15:0] mgmt_addr,
    input wire logic mgmt_wr,
    input wire logic mgmt_rd,
    input wire logic [15:0] mgmt_wdata,
    input wire logic [15:0] mgmt_rdata,
    // shared storage and status
    input wire logic mon_req,
    input wire logic mon_grant,
    input wire logic [1:0] cmd_status,
    input wire logic [2:0] cmd_code
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    logic csr_wr;
    logic csr_rd;
    assign csr_wr = mgmt_wr && mgmt_addr == NCS_CSR_ADDR;
    assign csr_rd = mgmt_rd && mgmt_addr == NCS_CSR_ADDR;

    chk_idle_write_starts: assert property (
        cmd_status == NCS_ST_IDLE && csr_wr |=> cmd_status == NCS_ST_BUSY)
        else $error("idle write did not start a command");
    chk_code_latched: assert property (
        cmd_status == NCS_ST_IDLE && csr_wr
        |=> cmd_code == {$past(mgmt_wdata[5]), $past(mgmt_wdata[1:0])})
        else $error("command code not taken from the write");
    // guard: reset may preload the upload code on its way out
    chk_code_held: assert property (
        $past(rst_b, 2) && cmd_status != NCS_ST_IDLE |=> $stable(cmd_code))
        else $error("command code moved before idle");
    chk_read_to_idle: assert property (
        cmd_status[0] && csr_rd |=> cmd_status == NCS_ST_IDLE
        && mgmt_rdata[3:2] == $past(cmd_status))
        else $error("outcome read did not return to idle");
    chk_fixed_bits: assert property (
        csr_rd |=> mgmt_rdata[8:6] == 3'h0 && mgmt_rdata[4] == 1'b0)
        else $error("reserved control bits not zero");
    chk_queued_wait: assert property (
        mon_grant && cmd_status == NCS_ST_BUSY |=> cmd_status == NCS_ST_BUSY)
        else $error("command ran while monitor owned storage");
    chk_mon_granted: assert property (
        mon_req && cmd_status == NCS_ST_IDLE && !mgmt_wr |=> mon_grant)
        else $error("monitor not granted free storage");
    chk_grant_drops: assert property (
        !mon_req |=> !mon_grant)
        else $error("grant kept after request dropped");
    chk_busy_ends: assert property (
        cmd_status == NCS_ST_BUSY |=> cmd_status != NCS_ST_IDLE)
        else $error("busy command skipped complete");
    cov_ok: cover property (cmd_status == NCS_ST_OK);
    cov_fail: cover property (cmd_status == NCS_ST_FAIL);
    cov_queued: cover property (mon_grant && cmd_status == NCS_ST_BUSY);
endmodule : ncs_sequencer_properties

bind ncs_sequencer ncs_sequencer_properties ncs_sequencer_properties_inst (
    .core_clk(core_clk), .rst_b(rst_b), .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
    .mgmt_rdata(mgmt_rdata), .mon_req(mon_req), .mon_grant(mon_grant),
    .cmd_status(cmd_status), .cmd_code(cmd_code)
);

/* bench/ncs_monitor_model.sv */
// optical monitor requester sharing the backing storage
module ncs_monitor_model #(
    parameter int HOLD = 20
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // one-cycle pulse asks for the storage
    input wire logic go,
    // storage handshake
    input wire logic mon_grant,
    output logic mon_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic req_reg;
    logic [7:0] cnt_reg;
    assign mon_req = req_reg;
    // request held until granted, then kept for HOLD+1 cycles
    always_ff @(posedge core_clk) begin
        if (!rst_b || (mon_grant && cnt_reg == HOLD[7:0])) begin
            req_reg <= 1'b0;
        end else if (go) begin
            req_reg <= 1'b1;
        end
    end
    always_ff @(posedge core_clk) begin
        if (!req_reg || !mon_grant) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end
endmodule : ncs_monitor_model

/* bench/ncs_sequencer_test.sv */
// self-checking bench for the stored map command sequencer
module ncs_sequencer_test
    import ncs_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CAP = 8'h5a;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] mgmt_addr = 16'h0000;
    logic mgmt_wr = 1'b0;
    logic mgmt_rd = 1'b0;
    logic [15:0] mgmt_wdata = 16'h0000;
    logic [15:0] mgmt_rdata;
    logic mon_req;
    logic mon_grant;
    logic mon_go = 1'b0;
    logic [1:0] cmd_status;
    logic [2:0] cmd_code;
    logic [15:0] rdv;
    int failures = 0;
    int num_checks = 0;
    // address, write data, expected readback
    logic [47:0] rows [7] = '{48'h8007_00a5_00a5, 48'h807e_1234_0034,
        48'h80ad_00ff_00ff, 48'h80f1_005a_005a, 48'h807a_00ff_005a,
        48'h8006_ffff_0000, 48'h80f2_ffff_0000};

    always #4 core_clk = ~core_clk;

    ncs_sequencer #(.MON_CAP_VALUE(CAP)) ncs_sequencer_inst (
        .core_clk(core_clk), .rst_b(rst_b), .mgmt_addr(mgmt_addr),
        .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata(mgmt_rdata), .mon_req(mon_req), .mon_grant(mon_grant),
        .cmd_status(cmd_status), .cmd_code(cmd_code));
    ncs_monitor_model ncs_monitor_model_inst (.core_clk(core_clk),
        .rst_b(rst_b), .go(mon_go), .mon_grant(mon_grant),
        .mon_req(mon_req));

    task finish_test;
        if (failures == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    task chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk);
        mgmt_addr <= a;
        mgmt_wdata <= d;
        mgmt_wr <= 1'b1;
        @(posedge core_clk);
        mgmt_wr <= 1'b0;
    endtask : wr

    task rd(input logic [15:0] a);
        @(posedge core_clk);
        mgmt_addr <= a;
        mgmt_rd <= 1'b1;
        @(posedge core_clk);
        mgmt_rd <= 1'b0;
        @(posedge core_clk);
        #1 rdv = mgmt_rdata;
    endtask : rd

    // bounded wait for the command to leave busy
    task wait_done;
        int n;
        n = 0;
        #1;
        while (cmd_status === NCS_ST_BUSY && n < 600) begin
            @(posedge core_clk);
            #1 n++;
        end
    endtask : wait_done

    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1 chk({14'h0, cmd_status}, 16'h0002);
        wait_done();
        rd(NCS_CSR_ADDR);
        chk(rdv, 16'h0007);
        chk({14'h0, cmd_status}, 16'h0000);
        foreach (rows[i]) begin
            wr(rows[i][47:32], rows[i][31:16]);
            rd(rows[i][47:32]);
            chk(rdv, rows[i][15:0]);
        end
        // commit, with a write in mid-command that must be dropped
        wr(NCS_CSR_ADDR, 16'hfe23);
        wr(NCS_CSR_ADDR, 16'h0000);
        #1 chk({13'h0, cmd_code}, 16'h0007);
        wait_done();
        rd(NCS_CSR_ADDR);
        chk(rdv, 16'hfe27);
        // volatile change is lost by a load of everything
        wr(16'h807e, 16'h0099);
        wr(NCS_CSR_ADDR, 16'hfe03);
        wait_done();
        rd(NCS_CSR_ADDR);
        chk(rdv, 16'hfe07);
        rd(16'h807e);
        chk(rdv, 16'h0034);
        // vendor extended code is not implemented here, so it fails
        wr(NCS_CSR_ADDR, 16'h0001);
        wait_done();
        rd(NCS_CSR_ADDR);
        chk(rdv, 16'h000d);
        // monitor owns storage first, so the commit queues
        @(posedge core_clk);
        mon_go <= 1'b1;
        @(posedge core_clk);
        mon_go <= 1'b0;
        repeat (3) @(posedge core_clk);
        wr(NCS_CSR_ADDR, 16'h0023);
        repeat (5) @(posedge core_clk);
        #1 chk({13'h0, mon_grant, cmd_status}, 16'h0006);
        wait_done();
        rd(NCS_CSR_ADDR);
        chk(rdv, 16'h0027);
        // mid-run reset drops a volatile edit and reloads the stored byte
        wr(16'h807e, 16'h0011);
        rst_b <= 1'b0;
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        #1 chk({13'h0, mon_grant, cmd_status}, 16'h0002);
        chk({13'h0, cmd_code}, 16'h0003);
        wait_done();
        rd(NCS_CSR_ADDR);
        chk(rdv, 16'h0007);
        rd(16'h807e);
        chk(rdv, 16'h0034);
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        failures++;
        finish_test();
    end
endmodule : ncs_sequencer_test
